// ==== sepr_defs.svh ====
/*
  Constants of the two-wire serial memory read path: control code, address
  layout, bus timing and buffer size. Assumes inclusion by bare name.
*/
`ifndef SEPR_DEFS_SVH
`define SEPR_DEFS_SVH

`define SEPR_CTRL_CODE     4'ha
`define SEPR_RW_READ       1'b1
`define SEPR_RW_WRITE      1'b0
`define SEPR_ADDR_W        11
`define SEPR_BLK_W         3
`define SEPR_MEM_DEPTH     2048
`define SEPR_CLK_PERIOD_NS 5
`define SEPR_SCL_PERIOD_NS 2500
`define SEPR_QTR_CYC       ((`SEPR_SCL_PERIOD_NS / 4) / `SEPR_CLK_PERIOD_NS)
`define SEPR_FIFO_DEPTH    8
`define SEPR_LEN_W         8

`endif

// ==== sepr_pkg.sv ====
/*
  Types for both ends of the read path: one state enum per end and the master's byte-role enum.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package sepr_pkg;
  typedef enum logic [3:0] {
    DS_IDLE, DS_CTRL, DS_ACKC, DS_ADDR, DS_ACKD, DS_WDAT, DS_RD, DS_RACK, DS_RNXT
  } sepr_dev_st_t;
  typedef enum logic [2:0] {HS_IDLE, HS_START, HS_BIT, HS_HOLD, HS_STOP} sepr_host_st_t;
  typedef enum logic [1:0] {RL_CTRL_W, RL_ADDR, RL_CTRL_R, RL_DATA} sepr_role_t;
endpackage : sepr_pkg
`default_nettype wire

// ==== sepr_if.sv ====
/*
  Two-wire bus between master and memory slave. Open-drain lines are
  resolved here as wired-and; each end only gives output and enable.
*/
`timescale 1ns/1ps
`default_nettype none
interface sepr_if;
  logic host_scl_o;
  logic host_scl_oe_n;
  logic host_sda_o;
  logic host_sda_oe_n;
  logic dev_sda_o;
  logic dev_sda_oe_n;
  logic scl_i;
  logic sda_i;

  // Pulled high unless some end drives low
  assign scl_i = !(!host_scl_oe_n && !host_scl_o);
  assign sda_i = !((!host_sda_oe_n && !host_sda_o) || (!dev_sda_oe_n && !dev_sda_o));

  modport host (output host_scl_o, host_scl_oe_n, host_sda_o, host_sda_oe_n,
                input scl_i, sda_i);
  modport dev  (output dev_sda_o, dev_sda_oe_n, input scl_i, sda_i);
endinterface : sepr_if
`default_nettype wire

// ==== sepr_dev.sv ====
/*
  Memory slave end: control byte decode, word address load, byte return
  with pointer advance. Assumes scl and sda are synchronous to sys_clk and
  each bus level lasts several clocks.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sepr_defs.svh"

module sepr_dev
  import sepr_pkg::*;
#(
  parameter int AW    = `SEPR_ADDR_W,
  parameter int DEPTH = `SEPR_MEM_DEPTH
)
(
  // Clock and reset
  input  wire logic          sys_clk,
  input  wire logic          arst_n,
  // Bus side
  sepr_if.dev                bus,
  // Array preload
  input  wire logic          load_en,
  input  wire logic [AW-1:0] load_addr,
  input  wire logic [7:0]    load_data,
  // Status
  input  wire logic          prog_busy,
  input  wire logic          supply_low,
  output logic      [AW-1:0] ptr_out
);

  generate
    if (AW != `SEPR_BLK_W + 8 || DEPTH != (1 << AW))
    begin : g_bad_size
      $error("sepr_dev: address width must be block bits plus eight");
    end
  endgenerate

  logic [7:0]     mem [DEPTH];
  sepr_dev_st_t   st_q, st_d;
  logic [3:0]     cnt_q, cnt_d;
  logic [7:0]     sh_q, sh_d;
  logic [AW-1:0]  ptr_q, ptr_d;
  logic [2:0]     blk_q, blk_d;
  logic           rd_q, rd_d;
  logic           drv_q, drv_d;
  logic           scl_q, sda_q;
  logic           rise, fall, start, stop;
  logic [7:0]     rdata;

  assign rise  = bus.scl_i && !scl_q;
  assign fall  = !bus.scl_i && scl_q;
  // Sda moving while scl stays high marks start or stop
  assign start = bus.scl_i && scl_q && sda_q && !bus.sda_i;
  assign stop  = bus.scl_i && scl_q && !sda_q && bus.sda_i;
  assign rdata = mem[ptr_q];

  assign bus.dev_sda_o    = 1'b0;
  assign bus.dev_sda_oe_n = !drv_q;
  assign ptr_out          = ptr_q;

  // Preload stands for the erase/write logic, so it obeys the supply detector
  always_ff @(posedge sys_clk)
  begin
    if (load_en && !supply_low)
    begin
      mem[load_addr] <= load_data;
    end
  end

  always_comb
  begin
    st_d  = st_q;
    cnt_d = cnt_q;
    sh_d  = sh_q;
    ptr_d = ptr_q;
    blk_d = blk_q;
    rd_d  = rd_q;
    drv_d = drv_q;
    if (start)
    begin
      // A start mid-write drops the write, pointer already loaded
      st_d  = DS_CTRL;
      cnt_d = 4'h0;
      drv_d = 1'b0;
    end
    else if (stop)
    begin
      st_d  = DS_IDLE;
      drv_d = 1'b0;
    end
    else
    begin
      case (st_q)
        DS_CTRL, DS_ADDR, DS_WDAT:
        begin
          if (rise)
          begin
            sh_d  = {sh_q[6:0], bus.sda_i};
            cnt_d = cnt_q + 4'h1;
          end
          else if (fall && cnt_q == 4'h8)
          begin
            if (prog_busy)
            begin
              st_d = DS_IDLE;
            end
            else if (st_q == DS_CTRL)
            begin
              if (sh_q[7:4] == `SEPR_CTRL_CODE)
              begin
                drv_d = 1'b1;
                st_d  = DS_ACKC;
                blk_d = sh_q[3:1];
                rd_d  = sh_q[0];
              end
              else
              begin
                st_d = DS_IDLE;
              end
            end
            else
            begin
              if (st_q == DS_ADDR)
              begin
                ptr_d = {blk_q, sh_q};
              end
              else
              begin
                // Written bytes are not stored, but count as accesses
                ptr_d = ptr_q + 11'h001;
              end
              drv_d = 1'b1;
              st_d  = DS_ACKD;
            end
          end
        end
        DS_ACKC:
        begin
          if (fall)
          begin
            cnt_d = 4'h0;
            if (rd_q == `SEPR_RW_READ)
            begin
              sh_d  = rdata;
              drv_d = !rdata[7];
              ptr_d = ptr_q + 11'h001;
              cnt_d = 4'h1;
              st_d  = DS_RD;
            end
            else
            begin
              drv_d = 1'b0;
              st_d  = DS_ADDR;
            end
          end
        end
        DS_ACKD:
        begin
          if (fall)
          begin
            drv_d = 1'b0;
            cnt_d = 4'h0;
            st_d  = DS_WDAT;
          end
        end
        DS_RD:
        begin
          if (fall)
          begin
            if (cnt_q == 4'h8)
            begin
              drv_d = 1'b0;
              st_d  = DS_RACK;
            end
            else
            begin
              sh_d  = {sh_q[6:0], 1'b0};
              drv_d = !sh_q[6];
              cnt_d = cnt_q + 4'h1;
            end
          end
        end
        DS_RACK:
        begin
          if (rise)
          begin
            // Nack leaves the line released for the master's stop
            st_d = bus.sda_i ? DS_IDLE : DS_RNXT;
          end
        end
        DS_RNXT:
        begin
          if (fall)
          begin
            sh_d  = rdata;
            drv_d = !rdata[7];
            ptr_d = ptr_q + 11'h001;
            cnt_d = 4'h1;
            st_d  = DS_RD;
          end
        end
        default:
        begin
          st_d  = DS_IDLE;
          drv_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_q  <= DS_IDLE;
      cnt_q <= 4'h0;
      sh_q  <= 8'h00;
      ptr_q <= 11'h000;
      blk_q <= 3'h0;
      rd_q  <= 1'b0;
      drv_q <= 1'b0;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
      sh_q  <= sh_d;
      ptr_q <= ptr_d;
      blk_q <= blk_d;
      rd_q  <= rd_d;
      drv_q <= drv_d;
      scl_q <= bus.scl_i;
      sda_q <= bus.sda_i;
    end
  end

endmodule : sepr_dev
`default_nettype wire

// ==== sepr_host.sv ====
/*
  Bus master end: current or random reads of 1 to 255 bytes, bytes land in a
  small FIFO. Assumes one sys_clk for both ends; scl is made by a divider.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sepr_defs.svh"

module sepr_fifo
#(
  parameter int W = 8,
  parameter int D = `SEPR_FIFO_DEPTH
)
(
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         arst_n,
  // Fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);
  localparam int PW = (D > 1) ? $clog2(D) : 1;

  generate
    if (D < 2 || (1 << PW) != D)
    begin : g_bad_depth
      $error("sepr_fifo: depth must be a power of two of at least two");
    end
  endgenerate

  logic [W-1:0] mem [D];
  logic [PW-1:0] wp_q, rp_q;
  logic [PW:0]   n_q;
  logic          push, pop;

  assign in_ready  = (n_q != D[PW:0]);
  assign out_valid = (n_q != '0);
  assign out_data  = mem[rp_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge sys_clk)
  begin
    if (push)
    begin
      mem[wp_q] <= in_data;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wp_q <= '0;
      rp_q <= '0;
      n_q  <= '0;
    end
    else
    begin
      wp_q <= wp_q + PW'(push);
      rp_q <= rp_q + PW'(pop);
      n_q  <= n_q + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule : sepr_fifo

module sepr_host
  import sepr_pkg::*;
#(
  parameter int QTR = `SEPR_QTR_CYC,
  parameter int LW  = `SEPR_LEN_W
)
(
  // Clock and reset
  input  wire logic          sys_clk,
  input  wire logic          arst_n,
  // Bus side
  sepr_if.host               bus,
  // Read command
  input  wire logic          cmd_valid,
  output logic               cmd_ready,
  input  wire logic          cmd_random,
  input  wire logic [10:0]   cmd_addr,
  input  wire logic [LW-1:0] cmd_len,
  // Read data
  output logic               rd_valid,
  input  wire logic          rd_ready,
  output logic      [7:0]    rd_data,
  // Status
  output logic               nack_err
);
  localparam int QW = (QTR > 1) ? $clog2(QTR) : 1;

  generate
    if (QTR < 2)
    begin : g_bad_qtr
      $error("sepr_host: quarter period must be at least two clocks");
    end
  endgenerate

  sepr_host_st_t st_q, st_d;
  sepr_role_t    role_q, role_d;
  logic [QW-1:0] qtr_q;
  logic [1:0]    ph_q, ph_d;
  logic [3:0]    bc_q, bc_d;
  logic [7:0]    tx_q, tx_d, rx_q, rx_d;
  logic [LW-1:0] left_q, left_d;
  logic [10:0]   addr_q, addr_d;
  logic          ackb_q, ackb_d, scl_lo_q, scl_lo_d, sda_lo_q, sda_lo_d;
  logic          push_q, push_d, nack_q, nack_d, tick, room;

  assign tick              = (qtr_q == QW'(QTR - 1));
  assign cmd_ready         = (st_q == HS_IDLE);
  assign bus.host_scl_o    = 1'b0;
  assign bus.host_sda_o    = 1'b0;
  assign bus.host_scl_oe_n = !scl_lo_q;
  assign bus.host_sda_oe_n = !sda_lo_q;
  assign nack_err          = nack_q;

  // A full FIFO holds scl high before the next byte
  sepr_fifo #(.W(8), .D(`SEPR_FIFO_DEPTH)) u_fifo (
    .sys_clk   (sys_clk),
    .arst_n    (arst_n),
    .in_valid  (push_q),
    .in_ready  (room),
    .in_data   (rx_q),
    .out_valid (rd_valid),
    .out_ready (rd_ready),
    .out_data  (rd_data)
  );

  always_comb
  begin
    st_d     = st_q;
    role_d   = role_q;
    ph_d     = ph_q;
    bc_d     = bc_q;
    tx_d     = tx_q;
    rx_d     = rx_q;
    left_d   = left_q;
    addr_d   = addr_q;
    ackb_d   = ackb_q;
    scl_lo_d = scl_lo_q;
    sda_lo_d = sda_lo_q;
    push_d   = 1'b0;
    nack_d   = 1'b0;
    if (st_q == HS_IDLE)
    begin
      // Idle bus is high, so the first start is just the sda fall of q3
      ph_d = 2'h2;
      if (cmd_valid)
      begin
        addr_d = cmd_addr;
        left_d = (cmd_len == '0) ? LW'(1) : cmd_len;
        role_d = cmd_random ? RL_CTRL_W : RL_CTRL_R;
        tx_d   = {`SEPR_CTRL_CODE, cmd_addr[10:8],
                  cmd_random ? `SEPR_RW_WRITE : `SEPR_RW_READ};
        st_d   = HS_START;
      end
    end
    else if (tick)
    begin
      ph_d = ph_q + 2'h1;
      if (st_q == HS_BIT && ph_q == 2'h2)
      begin
        if (bc_q < 4'h8)
        begin
          rx_d = {rx_q[6:0], bus.sda_i};
        end
        else
        begin
          ackb_d = bus.sda_i;
        end
      end
      if (ph_q == 2'h3)
      begin
        bc_d = 4'h0;
        case (st_q)
          HS_START: st_d = HS_BIT;
          HS_STOP:  st_d = HS_IDLE;
          HS_HOLD:
          begin
            if (room)
            begin
              st_d = HS_BIT;
            end
          end
          HS_BIT:
          begin
            if (bc_q < 4'h8)
            begin
              bc_d = bc_q + 4'h1;
              tx_d = {tx_q[6:0], 1'b0};
            end
            else if (role_q == RL_DATA)
            begin
              push_d = 1'b1;
              left_d = left_q - LW'(1);
              st_d   = (left_q == LW'(1)) ? HS_STOP : HS_HOLD;
            end
            else if (ackb_q)
            begin
              nack_d = 1'b1;
              st_d   = HS_STOP;
            end
            else
            begin
              case (role_q)
                RL_CTRL_W:
                begin
                  role_d = RL_ADDR;
                  tx_d   = addr_q[7:0];
                end
                RL_ADDR:
                begin
                  // Address acknowledged, now turn the bus round
                  role_d = RL_CTRL_R;
                  tx_d   = {`SEPR_CTRL_CODE, addr_q[10:8], `SEPR_RW_READ};
                  st_d   = HS_START;
                end
                default:
                begin
                  role_d = RL_DATA;
                  st_d   = HS_HOLD;
                end
              endcase
            end
          end
          default: st_d = HS_IDLE;
        endcase
      end
      // Line levels for the quarter now beginning
      case (st_d)
        HS_START:
        begin
          case (ph_d)
            2'h0:    scl_lo_d = 1'b1;
            2'h1:    sda_lo_d = 1'b0;
            2'h2:    scl_lo_d = 1'b0;
            default: sda_lo_d = 1'b1;
          endcase
        end
        HS_STOP:
        begin
          case (ph_d)
            2'h0:    scl_lo_d = 1'b1;
            2'h1:    sda_lo_d = 1'b1;
            2'h2:    scl_lo_d = 1'b0;
            default: sda_lo_d = 1'b0;
          endcase
        end
        HS_BIT:
        begin
          if (ph_d == 2'h0)
          begin
            scl_lo_d = 1'b1;
            if (role_d == RL_DATA)
            begin
              // Ack all but the last byte
              sda_lo_d = (bc_d == 4'h8) && (left_q != LW'(1));
            end
            else
            begin
              sda_lo_d = (bc_d < 4'h8) && !tx_d[7];
            end
          end
          else if (ph_d == 2'h2)
          begin
            scl_lo_d = 1'b0;
          end
        end
        default:
        begin
          scl_lo_d = scl_lo_q;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_q     <= HS_IDLE;
      role_q   <= RL_CTRL_W;
      qtr_q    <= '0;
      ph_q     <= 2'h3;
      bc_q     <= 4'h0;
      tx_q     <= 8'h00;
      rx_q     <= 8'h00;
      left_q   <= '0;
      addr_q   <= 11'h000;
      ackb_q   <= 1'b1;
      scl_lo_q <= 1'b0;
      sda_lo_q <= 1'b0;
      push_q   <= 1'b0;
      nack_q   <= 1'b0;
    end
    else
    begin
      st_q     <= st_d;
      role_q   <= role_d;
      qtr_q    <= tick ? '0 : qtr_q + QW'(1);
      ph_q     <= ph_d;
      bc_q     <= bc_d;
      tx_q     <= tx_d;
      rx_q     <= rx_d;
      left_q   <= left_d;
      addr_q   <= addr_d;
      ackb_q   <= ackb_d;
      scl_lo_q <= scl_lo_d;
      sda_lo_q <= sda_lo_d;
      push_q   <= push_d;
      nack_q   <= nack_d;
    end
  end

endmodule : sepr_host
`default_nettype wire

// ==== sepr_chk.sv ====
/*
  Checker for the two-wire link between master and memory slave ends.
  Assumes it sees the resolved bus levels and both ends' enables.
*/
`timescale 1ns/1ps
`default_nettype none

module sepr_chk (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Bus lines
  input wire logic host_scl_o,
  input wire logic host_scl_oe_n,
  input wire logic host_sda_o,
  input wire logic host_sda_oe_n,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe_n,
  input wire logic scl_i,
  input wire logic sda_i
);
  logic       scl_p_q, sda_p_q, fr_q, fr_d, ack0_q, ack0_d;
  logic [3:0] bit_q, bit_d;
  logic [1:0] byte_q, byte_d;
  logic [7:0] sh_q, sh_d, ctl_q, ctl_d;
  logic       rise, start, stop, slot;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  assign rise  = scl_i && !scl_p_q;
  assign start = scl_i && scl_p_q && sda_p_q && !sda_i;
  assign stop  = scl_i && scl_p_q && !sda_p_q && sda_i;
  // Ninth clock of any byte after the control byte
  assign slot  = fr_q && rise && bit_q == 4'h8 && byte_q != 2'h0;

  always_comb
  begin
    fr_d   = fr_q;
    bit_d  = bit_q;
    byte_d = byte_q;
    ack0_d = ack0_q;
    sh_d   = sh_q;
    ctl_d  = ctl_q;
    if (start)
    begin
      fr_d   = 1'b1;
      bit_d  = 4'h0;
      byte_d = 2'h0;
      ack0_d = 1'b0;
    end
    else if (stop)
      fr_d = 1'b0;
    else if (rise && bit_q == 4'h8)
    begin
      bit_d  = 4'h0;
      // Saturates at 3: only the first byte and the bytes after it matter
      byte_d = byte_q + {1'b0, byte_q != 2'h3};
      if (byte_q == 2'h0)
        ack0_d = !sda_i;
    end
    else if (rise)
    begin
      bit_d = bit_q + 4'h1;
      sh_d  = {sh_q[6:0], sda_i};
      if (bit_q == 4'h7 && byte_q == 2'h0)
        ctl_d = {sh_q[6:0], sda_i};
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
      fr_q    <= 1'b0;
      bit_q   <= 4'h0;
      byte_q  <= 2'h0;
      ack0_q  <= 1'b0;
      sh_q    <= 8'h00;
      ctl_q   <= 8'h00;
    end
    else
    begin
      scl_p_q <= scl_i;
      sda_p_q <= sda_i;
      fr_q    <= fr_d;
      bit_q   <= bit_d;
      byte_q  <= byte_d;
      ack0_q  <= ack0_d;
      sh_q    <= sh_d;
      ctl_q   <= ctl_d;
    end
  end

  property p_start_free; start |-> dev_sda_oe_n [*8]; endproperty
  property p_ctl_code;
    fr_q && rise && bit_q == 4'h8 && byte_q == 2'h0 |-> ctl_q[7:4] == 4'ha;
  endproperty
  property p_wr_ack; slot && !ctl_q[0] && ack0_q |-> !dev_sda_oe_n; endproperty
  property p_rd_slot_free; slot && ctl_q[0] |-> dev_sda_oe_n; endproperty
  property p_rd_host_free;
    fr_q && rise && bit_q inside {[4'h1:4'h7]} && byte_q != 2'h0 && ctl_q[0] |-> host_sda_oe_n;
  endproperty
  property p_rx_dev_free;
    fr_q && rise && bit_q < 4'h8 && !(byte_q != 2'h0 && ctl_q[0]) |-> dev_sda_oe_n;
  endproperty
  property p_nack_rel; slot && ctl_q[0] && sda_i |=> dev_sda_oe_n [*8]; endproperty
  property p_stop_free; stop |-> dev_sda_oe_n; endproperty
  property p_chg_low; $changed(dev_sda_oe_n) |-> !scl_i; endproperty

  a_start_free: assert property (p_start_free)
    else $error("slave drove data just after a start");
  a_ctl_code: assert property (p_ctl_code)
    else $error("control byte code is not the memory code");
  a_wr_ack: assert property (p_wr_ack)
    else $error("slave did not acknowledge a write-side byte");
  a_rd_slot_free: assert property (p_rd_slot_free)
    else $error("slave drove the master acknowledge slot");
  a_rd_host_free: assert property (p_rd_host_free)
    else $error("master drove data during a read byte");
  a_rx_dev_free: assert property (p_rx_dev_free)
    else $error("slave drove data while the master sends");
  a_nack_rel: assert property (p_nack_rel)
    else $error("slave kept data after master nack");
  a_stop_free: assert property (p_stop_free)
    else $error("slave drove data at a stop");
  a_chg_low: assert property (p_chg_low)
    else $error("slave changed data while clock high");

  c_seq_ack: cover property (slot && ctl_q[0] && !sda_i);
  c_rep_start: cover property (start && fr_q);
  c_ctl_nack: cover property (fr_q && rise && bit_q == 4'h8 && byte_q == 2'h0 && sda_i);
endmodule : sepr_chk

`default_nettype wire

// ==== serial_eeprom_read_path_tb.sv ====
/*
  Testbench: master and slave ends joined by the bus interface, array
  preloaded, reads checked against a local copy. Assumes QTR of 4.
*/
`timescale 1ns/1ps
`default_nettype none

module serial_eeprom_read_path_tb;
  typedef struct packed {logic rnd; logic [10:0] addr; logic [7:0] len;} sepr_row_t;
  logic        sys_clk, arst_n, load_en, prog_busy, supply_low;
  logic        cmd_valid, cmd_ready, cmd_random, rd_valid, rd_ready, nack_err;
  logic [10:0] load_addr, cmd_addr, ptr_out, exp_ptr;
  logic [7:0]  load_data, cmd_len, rd_data;
  logic [7:0]  mem [2048];
  int          bad_count, cmp_count, nack_cnt, n0;
  sepr_row_t   rows [5];

  sepr_if bus ();
  sepr_dev u_sepr_dev (.sys_clk(sys_clk), .arst_n(arst_n), .bus(bus.dev),
    .load_en(load_en), .load_addr(load_addr), .load_data(load_data),
    .prog_busy(prog_busy), .supply_low(supply_low), .ptr_out(ptr_out));
  sepr_host #(.QTR(4)) u_sepr_host (.sys_clk(sys_clk), .arst_n(arst_n), .bus(bus.host),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_random(cmd_random),
    .cmd_addr(cmd_addr), .cmd_len(cmd_len), .rd_valid(rd_valid), .rd_ready(rd_ready),
    .rd_data(rd_data), .nack_err(nack_err));
  sepr_chk u_sepr_chk (.sys_clk(sys_clk), .arst_n(arst_n),
    .host_scl_o(bus.host_scl_o), .host_scl_oe_n(bus.host_scl_oe_n),
    .host_sda_o(bus.host_sda_o), .host_sda_oe_n(bus.host_sda_oe_n),
    .dev_sda_o(bus.dev_sda_o), .dev_sda_oe_n(bus.dev_sda_oe_n),
    .scl_i(bus.scl_i), .sda_i(bus.sda_i));

  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk)
    if (nack_err === 1'b1)
      nack_cnt <= nack_cnt + 1;

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : stop_test

  // Bounded wait on cmd_ready (sel 1) or rd_valid (sel 0)
  task automatic wait_hi(input logic sel);
    int k;
    k = 0;
    while ((sel ? cmd_ready : rd_valid) !== 1'b1 && k < 4000)
    begin
      @(negedge sys_clk);
      k++;
    end
    chk("handshake wait", 16'(k < 4000), 16'h1);
  endtask : wait_hi

  // Hold delays popping so the FIFO fills; ok low means a refused read
  task automatic rd_cmd(input logic rnd, input logic [10:0] a, input logic [7:0] n,
                        input int hold, input logic ok);
    @(negedge sys_clk);
    chk("cmd_ready", 16'(cmd_ready), 16'h1);
    cmd_valid  = 1'b1;
    cmd_random = rnd;
    cmd_addr   = a;
    cmd_len    = n;
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    if (rnd && ok)
      exp_ptr = a;
    if (hold > 0)
    begin
      repeat (hold) @(negedge sys_clk);
      chk("stalled cmd_ready", 16'(cmd_ready), 16'h0);
    end
    for (int i = 0; i < int'(n) && ok; i++)
    begin
      wait_hi(1'b0);
      chk("rd_data", 16'(rd_data), 16'(mem[exp_ptr]));
      rd_ready = 1'b1;
      @(negedge sys_clk);
      rd_ready = 1'b0;
      exp_ptr  = exp_ptr + 11'h1;
    end
    wait_hi(1'b1);
    chk("rd_valid", 16'(rd_valid), 16'h0);
    chk("ptr_out", 16'(ptr_out), 16'(exp_ptr));
  endtask : rd_cmd

  initial
  begin
    #150000;
    chk("watchdog", 16'h0, 16'h1);
    stop_test();
  end

  initial
  begin
    {arst_n, load_en, prog_busy, supply_low, cmd_valid, cmd_random, rd_ready} = 7'h0;
    {load_addr, load_data, cmd_addr, cmd_len, exp_ptr} = 49'h0;
    {bad_count, cmp_count, nack_cnt} = {32'h0, 32'h0, 32'h0};
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    chk("reset outputs", 16'({cmd_ready, rd_valid, bus.dev_sda_oe_n, bus.host_sda_oe_n,
        bus.host_scl_oe_n}), 16'h17);
    chk("reset ptr_out", 16'(ptr_out), 16'h0);
    arst_n = 1'b1;
    for (int a = 0; a < 2048; a++)
    begin
      @(negedge sys_clk);
      mem[a]    = 8'(a) ^ 8'(a >> 8) ^ 8'h5a;
      load_en   = 1'b1;
      load_addr = 11'(a);
      load_data = mem[a];
    end
    @(negedge sys_clk);
    load_en = 1'b0;
    $display("test reset and preload done");
    // Current reads send stray block bits; the pointer must win
    rows = '{'{1'b1, 11'h123, 8'h1}, '{1'b0, 11'h000, 8'h2}, '{1'b1, 11'h7fe, 8'h3},
             '{1'b1, 11'h2f0, 8'h1}, '{1'b0, 11'h5a5, 8'h1}};
    foreach (rows[r])
    begin
      rd_cmd(rows[r].rnd, rows[r].addr, rows[r].len, 0, 1'b1);
      $display("test row %0d done", r);
    end
    rd_cmd(1'b1, 11'h040, 8'd10, 2016, 1'b1);
    $display("test buffer fill and drain done");
    @(negedge sys_clk);
    supply_low = 1'b1;
    load_en    = 1'b1;
    load_addr  = 11'h045;
    load_data  = ~mem[11'h045];
    @(negedge sys_clk);
    supply_low     = 1'b0;
    load_addr      = 11'h046;
    load_data      = 8'hc3;
    mem[11'h046]   = 8'hc3;
    @(negedge sys_clk);
    load_en = 1'b0;
    rd_cmd(1'b1, 11'h045, 8'd2, 0, 1'b1);
    $display("test low supply done");
    @(negedge sys_clk);
    prog_busy = 1'b1;
    n0        = nack_cnt;
    rd_cmd(1'b1, 11'h300, 8'd1, 0, 1'b0);
    chk("nack_err pulses", 16'(nack_cnt - n0), 16'h1);
    prog_busy = 1'b0;
    rd_cmd(1'b0, 11'h300, 8'd1, 0, 1'b1);
    $display("test busy refusal done");
    stop_test();
  end
endmodule : serial_eeprom_read_path_tb

`default_nettype wire
